// ==== shared/psts_pkg.sv ====
// constants, field layouts and carrier types of the pid self-tuning sequencer
// assumes a 100 MHz system clock and an ahb-lite master with one slave
// How it works
// - transistor output gets configurable on delay flag
// - mode code 0 off, 1-4 starting, 4 also vibration
// - vibration tuning only with mode code four
// - starting tuning at control start or set change
// - vibration tuning when stable loop starts oscillating
// - tuning start clears bit0, raises active flag
// - poor response stores constants, sets bit0
// - tuning end drops the active flag
// - self-tuning standard mode only; auto tuning both
// - request rise starts auto tuning; update at end
// - auto tuning alone updates loop break time, in standard control only
// - self-tuning never toggles the manipulated value
// - auto tuning drives manipulated value on/off
// - self-tuning prevented by pid not full sets status bit eight
// - failed or timed out tuning sets bit ten
package psts_pkg;
  // sizes
  localparam int CH_NUM = 4;
  localparam int ADDR_W = 12;
  localparam int MODE_W = 3;
  localparam int STW_W = 16;
  localparam int LBJ_W = 16;
  localparam int ONDLY_W = 16;
  localparam int TMR_W = 40;
  localparam int IRQ_W = 12;
  // timing, time figure first, cycle count derived from the rate
  localparam int CLK_HZ = 100_000_000;
  localparam int ST_TIMEOUT_S = 6000;
  localparam logic [63:0] ST_TIMEOUT_CYC64 = 64'(ST_TIMEOUT_S) * 64'(CLK_HZ);
  localparam logic [TMR_W-1:0] ST_TIMEOUT_CYC = ST_TIMEOUT_CYC64[TMR_W-1:0];
  localparam int ON_TICK_MS = 1;
  localparam logic [31:0] ON_TICK_CYC = 32'(CLK_HZ / 1000 * ON_TICK_MS);
  // tuning mode codes
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
  localparam logic [MODE_W-1:0] MODE_PID = 3'h1;
  localparam logic [MODE_W-1:0] MODE_RISE = 3'h2;
  localparam logic [MODE_W-1:0] MODE_BOTH = 3'h3;
  localparam logic [MODE_W-1:0] MODE_VIB = 3'h4;
  // tuning status word bits
  localparam int STW_AUTOCORR = 0;
  localparam int STW_DISABLE = 8;
  localparam int STW_ERROR = 10;
  // byte offsets of the register file
  localparam logic [ADDR_W-1:0] OFS_MODE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_ONDLY = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_STW_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_STW_STEP = 12'h004;
  // loop break judge time is placed by word index; byte address is index times four
  localparam logic [ADDR_W-1:0] LBJ_IDX_CH1 = 12'h116;
  localparam logic [ADDR_W-1:0] LBJ_IDX_STEP = 12'h030;
  // field positions
  localparam int CTRL_HEATCOOL = 0;
  localparam int CTRL_REQ_LSB = 4;
  localparam int FLG_ACT_LSB = 0;
  localparam int FLG_OND_LSB = 4;
  localparam int FLG_AT_LSB = 8;
  localparam int IRQ_DONE_LSB = 0;
  localparam int IRQ_ERR_LSB = 4;
  localparam int IRQ_AT_LSB = 8;
  // reset values
  localparam logic [ONDLY_W-1:0] ONDLY_RST = 16'h0000;
  localparam logic [LBJ_W-1:0] LBJ_RST = 16'h0000;
  localparam int HTRANS_ACT_BIT = 1;
  // channel sequencer states
  typedef enum logic [1:0] {CH_IDLE, CH_ST, CH_VIB, CH_AT} psts_ch_state_type;
  // per-channel signals from the control and analysis logic
  typedef struct packed {
    logic run;
    logic sv_change;
    logic oscillation;
    logic resp_done;
    logic resp_poor;
    logic st_fail;
    logic pid_full;
    logic at_done;
    logic [LBJ_W-1:0] lbj;
    logic tout_req;
  } psts_ch_in_type;
  // ahb-lite slave inputs and outputs
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } psts_ahb_in_type;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } psts_ahb_out_type;
endpackage

// ==== design/psts_on_delay.sv ====
// on delay timers for the transistor outputs of all channels
// assumes requests come from logic on the same clock
`timescale 1ns/1ps
module psts_on_delay #(
  parameter int P_NCH = 4,
  parameter logic [31:0] P_TICK_CYC = psts_pkg::ON_TICK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [P_NCH-1:0] i_req,
  input wire logic [psts_pkg::ONDLY_W-1:0] i_delay,
  output logic [P_NCH-1:0] o_tout,
  output logic [P_NCH-1:0] o_flag
);
  import psts_pkg::*;

  if (P_TICK_CYC < 32'h1) begin : g_bad_tick
    $error("tick period must be at least one cycle");
  end

  // whole state of the timers
  typedef struct packed {
    logic [31:0] pre;
    logic [P_NCH-1:0][ONDLY_W-1:0] cnt;
    logic [P_NCH-1:0] tout;
    logic [P_NCH-1:0] flag;
  } psts_ond_state_type;

  psts_ond_state_type s_q;
  psts_ond_state_type s_d;

  // prescaler and per-channel delay counters
  always_comb begin
    logic tick;
    tick = (s_q.pre == P_TICK_CYC - 32'h1);
    s_d = s_q;
    s_d.pre = tick ? 32'h0 : s_q.pre + 32'h1;
    for (int c = 0; c < P_NCH; c++) begin
      s_d.tout[c] = i_req[c];
      if (!i_req[c]) begin
        // output off: the flag follows at once
        s_d.cnt[c] = '0;
        s_d.flag[c] = 1'b0;
      end else if (s_q.cnt[c] >= i_delay) begin
        s_d.flag[c] = 1'b1;
      end else if (tick) begin
        // counting whole ticks, so the lag can be one tick short
        s_d.cnt[c] = s_q.cnt[c] + 16'h1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tout = s_q.tout;
  assign o_flag = s_q.flag;
endmodule

// ==== design/psts_top.sv ====
// per-channel self-tuning and auto tuning sequencer with ahb-lite registers
// assumes channel inputs are synchronous to i_clk_sys and one bus master
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module psts_top #(
  parameter int P_NCH = 4,
  parameter logic [psts_pkg::TMR_W-1:0] P_ST_TIMEOUT_CYC = psts_pkg::ST_TIMEOUT_CYC,
  parameter logic [31:0] P_TICK_CYC = psts_pkg::ON_TICK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire psts_pkg::psts_ahb_in_type i_ahb,
  output psts_pkg::psts_ahb_out_type o_ahb,
  input wire psts_pkg::psts_ch_in_type [P_NCH-1:0] i_ch,
  output logic [P_NCH-1:0] o_tuning_active,
  output logic [P_NCH-1:0] o_at_mv_onoff,
  output logic [P_NCH-1:0] o_pid_write,
  output logic [P_NCH-1:0] o_rise_write,
  output logic [P_NCH-1:0] o_tout,
  output logic [P_NCH-1:0] o_on_delay_flag,
  output logic o_irq
);
  import psts_pkg::*;

  // register layout holds at most four channels
  if (P_NCH < 1 || P_NCH > CH_NUM) begin : g_bad_nch
    $error("channel count must be 1 to 4");
  end
  if (P_ST_TIMEOUT_CYC < 40'h1) begin : g_bad_tmo
    $error("timeout must be at least one cycle");
  end

  // one channel sequencer
  typedef struct packed {
    psts_ch_state_type st;
    logic run_prev;
    logic req_prev;
    logic [TMR_W-1:0] tmr;
    logic [STW_W-1:0] stw;
    logic [LBJ_W-1:0] lbj;
  } psts_chst_type;

  // whole state of the block
  typedef struct packed {
    psts_chst_type [P_NCH-1:0] ch;
    logic [P_NCH*MODE_W-1:0] mode;
    logic [P_NCH-1:0] req;
    logic heat_cool;
    logic [P_NCH-1:0] act;
    logic [P_NCH-1:0] mvon;
    logic [P_NCH-1:0] pidw;
    logic [P_NCH-1:0] risew;
    logic [ONDLY_W-1:0] ondly;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] hrdata;
    logic hready;
  } psts_state_type;

  psts_state_type s_q;
  psts_state_type s_d;
  logic [P_NCH-1:0] ond_flag; // from the on delay timers
  logic [P_NCH-1:0] tout_req; // transistor output requests

  // byte address of a channel's status word
  function automatic logic [ADDR_W-1:0] stw_addr(input int c);
    stw_addr = ADDR_W'(OFS_STW_BASE + OFS_STW_STEP * ADDR_W'(c));
  endfunction

  // byte address of a channel's loop break judge time, four times its index
  function automatic logic [ADDR_W-1:0] lbj_addr(input int c);
    logic [ADDR_W+1:0] idx;
    idx = (ADDR_W+2)'(LBJ_IDX_CH1 + LBJ_IDX_STEP * ADDR_W'(c));
    lbj_addr = ADDR_W'(idx << 2);
  endfunction

  // bus slave, register file, channel sequencers and interrupt
  always_comb begin
    logic take;
    logic [ADDR_W-1:0] a;
    logic [31:0] rd;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [MODE_W-1:0] md;
    logic at_start;
    logic run_rise;
    logic st_ok;
    take = i_ahb.hsel & i_ahb.htrans[HTRANS_ACT_BIT] & i_ahb.hready;
    a = i_ahb.haddr[ADDR_W-1:0];
    rd = '0;
    ev = '0;
    clr = '0;
    md = '0;
    at_start = 1'b0;
    run_rise = 1'b0;
    st_ok = 1'b0;
    s_d = s_q;
    s_d.pidw = '0;
    s_d.risew = '0;

    // write data phase: one wait state, so a read right after sees the new value
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      s_d.hready = 1'b1;
      case (s_q.wr_addr)
        OFS_MODE: s_d.mode = i_ahb.hwdata[P_NCH*MODE_W-1:0];
        OFS_CTRL: begin
          s_d.heat_cool = i_ahb.hwdata[CTRL_HEATCOOL];
          s_d.req = i_ahb.hwdata[CTRL_REQ_LSB +: P_NCH];
        end
        OFS_ONDLY: s_d.ondly = i_ahb.hwdata[ONDLY_W-1:0];
        OFS_IRQ_CLR: clr = i_ahb.hwdata[IRQ_W-1:0];
        OFS_IRQ_EN: s_d.irq_en = i_ahb.hwdata[IRQ_W-1:0];
        default: ; // read-only or unmapped: ignored
      endcase
      for (int c = 0; c < P_NCH; c++) begin
        if (s_q.wr_addr == lbj_addr(c)) begin
          s_d.ch[c].lbj = i_ahb.hwdata[LBJ_W-1:0];
        end
      end
    end

    // read mux, unmapped addresses read zero
    case (a)
      OFS_MODE: rd[P_NCH*MODE_W-1:0] = s_q.mode;
      OFS_CTRL: begin
        rd[CTRL_HEATCOOL] = s_q.heat_cool;
        rd[CTRL_REQ_LSB +: P_NCH] = s_q.req;
      end
      OFS_FLAGS: begin
        rd[FLG_ACT_LSB +: P_NCH] = s_q.act;
        rd[FLG_OND_LSB +: P_NCH] = ond_flag;
        rd[FLG_AT_LSB +: P_NCH] = s_q.mvon;
      end
      OFS_ONDLY: rd[ONDLY_W-1:0] = s_q.ondly;
      OFS_IRQ_STAT: rd[IRQ_W-1:0] = s_q.irq_st;
      OFS_IRQ_EN: rd[IRQ_W-1:0] = s_q.irq_en;
      default: ; // per-channel words below
    endcase
    for (int c = 0; c < P_NCH; c++) begin
      if (a == stw_addr(c)) begin
        rd[STW_W-1:0] = s_q.ch[c].stw;
      end
      if (a == lbj_addr(c)) begin
        rd[LBJ_W-1:0] = s_q.ch[c].lbj;
      end
    end

    // address phase
    if (take) begin
      if (i_ahb.hwrite) begin
        s_d.wr_pend = 1'b1;
        s_d.wr_addr = a;
        s_d.hready = 1'b0;
      end else begin
        s_d.hrdata = rd;
      end
    end

    // channel sequencers, all running side by side
    for (int c = 0; c < P_NCH; c++) begin
      md = s_q.mode[c*MODE_W +: MODE_W];
      at_start = s_q.req[c] & ~s_q.ch[c].req_prev;
      run_rise = i_ch[c].run & ~s_q.ch[c].run_prev;
      // self-tuning needs a mode, standard control and full pid
      st_ok = (md != MODE_OFF) & ~s_q.heat_cool & i_ch[c].pid_full & i_ch[c].run;
      s_d.ch[c].req_prev = s_q.req[c];
      s_d.ch[c].run_prev = i_ch[c].run;
      s_d.ch[c].stw[STW_DISABLE] = (md != MODE_OFF) & ~i_ch[c].pid_full;
      case (s_q.ch[c].st)
        CH_IDLE: begin
          if (at_start) begin
            // auto tuning runs in either control mode
            s_d.ch[c].st = CH_AT;
            s_d.act[c] = 1'b1;
            s_d.mvon[c] = 1'b1;
          end else if (st_ok && (run_rise || i_ch[c].sv_change)) begin
            s_d.ch[c].st = CH_ST;
            s_d.act[c] = 1'b1;
            s_d.ch[c].stw[STW_AUTOCORR] = 1'b0;
            s_d.ch[c].stw[STW_ERROR] = 1'b0;
            s_d.ch[c].tmr = '0;
          end else if (st_ok && md == MODE_VIB && i_ch[c].oscillation) begin
            s_d.ch[c].st = CH_VIB;
            s_d.act[c] = 1'b1;
            s_d.ch[c].stw[STW_AUTOCORR] = 1'b0;
            s_d.ch[c].stw[STW_ERROR] = 1'b0;
            s_d.ch[c].tmr = '0;
          end
        end
        CH_ST, CH_VIB: begin
          // the manipulated value is left to the control loop here
          s_d.ch[c].tmr = s_q.ch[c].tmr + 40'h1;
          if (at_start) begin
            // auto tuning takes over; self-tuning is not run meanwhile
            s_d.ch[c].st = CH_AT;
            s_d.mvon[c] = 1'b1;
          end else if (md == MODE_OFF || !i_ch[c].run || s_q.heat_cool) begin
            // discontinued without error
            s_d.ch[c].st = CH_IDLE;
            s_d.act[c] = 1'b0;
          end else if (i_ch[c].st_fail || s_q.ch[c].tmr >= P_ST_TIMEOUT_CYC - 40'h1) begin
            s_d.ch[c].stw[STW_ERROR] = 1'b1;
            s_d.ch[c].st = CH_IDLE;
            s_d.act[c] = 1'b0;
            ev[IRQ_ERR_LSB + c] = 1'b1;
          end else if (i_ch[c].resp_done) begin
            if (i_ch[c].resp_poor || s_q.ch[c].st == CH_VIB) begin
              // new constants computed while control ran undisturbed
              s_d.pidw[c] = (md != MODE_RISE);
              s_d.risew[c] = (md == MODE_RISE) || (md == MODE_BOTH);
              s_d.ch[c].stw[STW_AUTOCORR] = 1'b1;
            end
            s_d.ch[c].st = CH_IDLE;
            s_d.act[c] = 1'b0;
            ev[IRQ_DONE_LSB + c] = 1'b1;
          end
        end
        CH_AT: begin
          if (i_ch[c].at_done) begin
            s_d.pidw[c] = 1'b1;
            if (!s_q.heat_cool) begin
              s_d.ch[c].lbj = i_ch[c].lbj;
            end
            s_d.mvon[c] = 1'b0;
            s_d.act[c] = 1'b0;
            s_d.ch[c].st = CH_IDLE;
            ev[IRQ_AT_LSB + c] = 1'b1;
          end
        end
        default: begin
          s_d.ch[c].st = CH_IDLE;
          s_d.act[c] = 1'b0;
          s_d.mvon[c] = 1'b0;
        end
      endcase
    end

    // sticky status: an event in the clearing cycle survives
    s_d.irq_st = (s_q.irq_st & ~clr) | ev;
    s_d.irq = |(s_d.irq_st & s_d.irq_en);
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_q <= '0;
      s_q.ondly <= ONDLY_RST;
      s_q.hready <= 1'b1;
      for (int c = 0; c < P_NCH; c++) begin
        s_q.ch[c].st <= CH_IDLE;
        s_q.ch[c].lbj <= LBJ_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // transistor output with its on delay flag
  psts_on_delay #(
    .P_NCH(P_NCH),
    .P_TICK_CYC(P_TICK_CYC)
  ) u_on_delay (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_req(tout_req),
    .i_delay(s_q.ondly),
    .o_tout(o_tout),
    .o_flag(ond_flag)
  );

  // gather the per-channel transistor output requests
  always_comb begin
    for (int c = 0; c < P_NCH; c++) begin
      tout_req[c] = i_ch[c].tout_req;
    end
  end

  assign o_on_delay_flag = ond_flag;
  assign o_tuning_active = s_q.act;
  assign o_at_mv_onoff = s_q.mvon;
  assign o_pid_write = s_q.pidw;
  assign o_rise_write = s_q.risew;
  assign o_irq = s_q.irq;
  assign o_ahb.hrdata = s_q.hrdata;
  assign o_ahb.hreadyout = s_q.hready;
  assign o_ahb.hresp = 1'b0;

  // checks on channel 0, the interrupt and the bus
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  a_wr_wait_state: assert property (
    i_ahb.hsel && i_ahb.htrans[HTRANS_ACT_BIT] && i_ahb.hwrite && o_ahb.hreadyout
    |=> !o_ahb.hreadyout ##1 o_ahb.hreadyout)
    else $error("write wait state wrong");
  a_irq_level: assert property (o_irq == |(s_q.irq_st & s_q.irq_en))
    else $error("irq level mismatch");
  a_start_clears_b0: assert property (
    $rose(s_q.ch[0].st == CH_ST) |-> o_tuning_active[0] && !s_q.ch[0].stw[STW_AUTOCORR])
    else $error("start did not clear bit0 or raise flag");
  a_vib_needs_mode4: assert property (
    $rose(s_q.ch[0].st == CH_VIB) |-> $past(s_q.mode[MODE_W-1:0]) == MODE_VIB)
    else $error("vibration tuning without mode four");
  a_end_drops_flag: assert property (
    $past(s_q.ch[0].st == CH_ST) && s_q.ch[0].st == CH_IDLE |-> !o_tuning_active[0])
    else $error("active flag kept after tuning");
  a_hc_no_st: assert property (
    $rose(s_q.ch[0].st == CH_ST || s_q.ch[0].st == CH_VIB) |-> !$past(s_q.heat_cool))
    else $error("self-tuning in heating-cooling mode");
  a_st_keeps_lbj: assert property (
    $past(s_q.ch[0].st != CH_AT) |-> $stable(s_q.ch[0].lbj) || $past(s_q.wr_pend))
    else $error("self-tuning changed loop break time");
  a_st_no_mv: assert property (
    s_q.ch[0].st == CH_ST || s_q.ch[0].st == CH_VIB |-> !o_at_mv_onoff[0])
    else $error("manipulated value toggled in self-tuning");
  a_poor_sets_b0: assert property (
    s_q.ch[0].st == CH_ST && i_ch[0].resp_done && i_ch[0].resp_poor && !i_ch[0].st_fail
    && i_ch[0].run && !s_q.heat_cool && s_q.mode[MODE_W-1:0] == MODE_PID
    && s_q.req[0] == s_q.ch[0].req_prev && s_q.ch[0].tmr < P_ST_TIMEOUT_CYC - 40'h1
    |=> o_pid_write[0] && s_q.ch[0].stw[STW_AUTOCORR] ##1 !o_pid_write[0])
    else $error("poor response did not store constants");
  a_disable_b8: assert property (
    s_q.mode[MODE_W-1:0] != MODE_OFF && !i_ch[0].pid_full |=> s_q.ch[0].stw[STW_DISABLE])
    else $error("disable bit not set");
endmodule

// ==== tb/psts_master_model.sv ====
// ahb-lite master standing in for the network master program
// assumes one slave whose hreadyout the bench loops back as hready
`timescale 1ns/1ps
module psts_master_model (
  input wire logic i_clk_sys,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output psts_pkg::psts_ahb_in_type o_bus
);
  import psts_pkg::*;
  // idle bus from time zero
  initial begin
    o_bus = '0;
  end
  // one word transfer; each phase is held until hready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge i_clk_sys);
    o_bus.hsel <= 1'b1;
    o_bus.haddr <= a;
    o_bus.htrans <= 2'h2;
    o_bus.hwrite <= w;
    o_bus.hsize <= 3'h2;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    o_bus.hsel <= 1'b0;
    o_bus.htrans <= 2'h0;
    // a read leaves hwdata released, so it toggles rather than holding
    o_bus.hwdata <= w ? d : ~o_bus.hwdata;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    r = i_hrdata;
  endtask
endmodule

// ==== tb/pid_self_tuning_sequencer_test.sv ====
// register and sequencer tests of the self-tuning block, channels 0 and 1
// assumes shortened timeout (200 cycles) and on delay tick (4 cycles)
`timescale 1ns/1ps
module pid_self_tuning_sequencer_test;
  import psts_pkg::*;
  logic clk = 1'b0; // 100 MHz
  logic nrst = 1'b0; // active low reset
  psts_ahb_in_type ahb_i; // master request plus loopback hready
  psts_ahb_out_type ahb_o;
  psts_ahb_in_type m_bus;
  psts_ch_in_type [3:0] ch = '0; // process side stimulus
  logic [3:0] act, mvon, pw, rw, tout, odf;
  logic irq;
  logic [31:0] rdv;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  localparam logic [31:0] LBJ0 = 32'(LBJ_IDX_CH1) * 32'h4;
  localparam logic [31:0] STW0 = 32'(OFS_STW_BASE);
  always #5 clk = ~clk;
  always_comb begin
    ahb_i = m_bus;
    ahb_i.hready = ahb_o.hreadyout;
  end
  psts_master_model u_master (.i_clk_sys(clk), .i_hready(ahb_o.hreadyout),
    .i_hrdata(ahb_o.hrdata), .o_bus(m_bus));
  psts_top #(.P_NCH(4), .P_ST_TIMEOUT_CYC(40'd200), .P_TICK_CYC(32'd4)) dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_ahb(ahb_i), .o_ahb(ahb_o), .i_ch(ch),
    .o_tuning_active(act), .o_at_mv_onoff(mvon), .o_pid_write(pw),
    .o_rise_write(rw), .o_tout(tout), .o_on_delay_flag(odf), .o_irq(irq));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, generous against the few hundred cycles used
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_master.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a);
    u_master.xfer(1'b0, a, 32'h0, rdv);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // bounded wait for channel 0 active flag to reach v
  task automatic wact(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && act[0] !== v; i++) @(posedge clk);
    chk(32'(act[0]), 32'(v));
  endtask
  initial begin
    tick(3);
    nrst <= 1'b1;
    ch[0].pid_full <= 1'b1;
    ch[1].pid_full <= 1'b1;
    tick(1);
    rd(32'(OFS_MODE));
    chk(rdv, 32'h0);
    rd(32'h0000_0800);
    chk(rdv, 32'h0);
    wr(32'(OFS_IRQ_EN), 32'h0000_0FFF);
    // both channels start together on run rising
    wr(32'(OFS_MODE), 32'h0000_0009);
    ch[0].run <= 1'b1;
    ch[1].run <= 1'b1;
    tick(2);
    chk(32'(act), 32'h3);
    rd(STW0);
    chk(rdv, 32'h0);
    ch[0].resp_done <= 1'b1;
    ch[0].resp_poor <= 1'b1;
    tick(1);
    ch[0].resp_done <= 1'b0;
    wact(1'b0, 4);
    chk(32'({pw[0], rw[0], act[1]}), 32'h5);
    rd(STW0);
    chk(rdv, 32'h1);
    rd(LBJ0);
    chk(rdv, 32'h0);
    rd(32'(OFS_IRQ_STAT));
    chk(rdv, 32'h1);
    chk(32'(irq), 32'h1);
    wr(32'(OFS_IRQ_CLR), 32'h1);
    rd(32'(OFS_IRQ_STAT));
    chk(32'({rdv[0], irq}), 32'h0);
    // channel 1 good response keeps its constants
    ch[1].resp_done <= 1'b1;
    ch[1].resp_poor <= 1'b0;
    tick(1);
    ch[1].resp_done <= 1'b0;
    tick(1);
    chk(32'({pw[1], act[1]}), 32'h0);
    rd(STW0 + 32'h4);
    chk(rdv, 32'h0);
    wr(32'(OFS_IRQ_EN), 32'h0);
    tick(2);
    chk(32'(irq), 32'h0);
    wr(32'(OFS_IRQ_EN), 32'h0000_0FFF);
    wr(32'(OFS_IRQ_CLR), 32'h0000_0FFF);
    // set value change restarts, then an analysis fault ends it
    ch[0].sv_change <= 1'b1;
    tick(1);
    ch[0].sv_change <= 1'b0;
    wact(1'b1, 4);
    rd(STW0);
    chk(rdv, 32'h0);
    ch[0].st_fail <= 1'b1;
    tick(1);
    ch[0].st_fail <= 1'b0;
    wact(1'b0, 4);
    rd(STW0);
    chk(rdv, 32'h400);
    // run that never completes times out
    ch[0].sv_change <= 1'b1;
    tick(1);
    ch[0].sv_change <= 1'b0;
    wact(1'b1, 4);
    tick(150);
    chk(32'(act[0]), 32'h1);
    wact(1'b0, 80);
    rd(STW0);
    chk(rdv, 32'h400);
    rd(32'(OFS_IRQ_STAT));
    chk(rdv & 32'h10, 32'h10);
    // oscillation ignored until mode four
    ch[0].oscillation <= 1'b1;
    tick(4);
    chk(32'(act[0]), 32'h0);
    wr(32'(OFS_MODE), 32'h0000_000C);
    wact(1'b1, 4);
    ch[0].oscillation <= 1'b0;
    chk(32'(mvon[0]), 32'h0);
    ch[0].resp_done <= 1'b1;
    ch[0].resp_poor <= 1'b0;
    tick(1);
    ch[0].resp_done <= 1'b0;
    wact(1'b0, 4);
    chk(32'(pw[0]), 32'h1);
    ch[0].pid_full <= 1'b0;
    tick(2);
    rd(STW0);
    chk(rdv, 32'h101);
    ch[0].pid_full <= 1'b1;
    // heating-cooling: no self-tuning, auto tuning still runs
    wr(32'(OFS_CTRL), 32'h1);
    ch[0].sv_change <= 1'b1;
    tick(1);
    ch[0].sv_change <= 1'b0;
    tick(4);
    chk(32'(act[0]), 32'h0);
    wr(32'(OFS_CTRL), 32'h11);
    wact(1'b1, 4);
    chk(32'(mvon[0]), 32'h1);
    rd(32'(OFS_FLAGS));
    chk(rdv, 32'h101);
    ch[0].lbj <= 16'h1234;
    ch[0].at_done <= 1'b1;
    tick(1);
    ch[0].at_done <= 1'b0;
    wact(1'b0, 4);
    chk(32'({pw[0], mvon[0]}), 32'h2);
    rd(LBJ0);
    chk(rdv, 32'h0);
    // standard control: request off then on, time value is loaded
    wr(32'(OFS_CTRL), 32'h0);
    wr(32'(OFS_CTRL), 32'h10);
    wact(1'b1, 4);
    ch[0].at_done <= 1'b1;
    tick(1);
    ch[0].at_done <= 1'b0;
    wact(1'b0, 4);
    rd(LBJ0);
    chk(rdv, 32'h1234);
    rd(32'(OFS_IRQ_STAT));
    chk(rdv & 32'h100, 32'h100);
    // on delay of two ticks
    wr(32'(OFS_ONDLY), 32'h2);
    ch[0].tout_req <= 1'b1;
    tick(2);
    chk(32'({tout[0], odf[0]}), 32'h2);
    for (n = 0; n < 40 && odf[0] !== 1'b1; n++) @(posedge clk);
    chk(32'(n >= 2 && n < 16), 32'h1);
    ch[0].tout_req <= 1'b0;
    tick(3);
    chk(32'({tout[0], odf[0]}), 32'h0);
    // channel 1 in mode three, then mode two: the rise parameter is stored
    for (n = 0; n < 2; n++) begin
      wr(32'(OFS_MODE), (n == 0) ? 32'h0000_001C : 32'h0000_0014);
      ch[1].sv_change <= 1'b1;
      ch[1].resp_poor <= 1'b1;
      tick(1);
      ch[1].sv_change <= 1'b0;
      ch[1].resp_done <= 1'b1;
      tick(1);
      ch[1].resp_done <= 1'b0;
      tick(1);
      chk(32'({pw[1], rw[1], act[1]}), (n == 0) ? 32'h6 : 32'h2);
    end
    // mode zero ends a run without the error bit
    ch[1].sv_change <= 1'b1;
    tick(1);
    ch[1].sv_change <= 1'b0;
    tick(1);
    chk(32'(act[1]), 32'h1);
    wr(32'(OFS_MODE), 32'h0000_0004);
    tick(1);
    chk(32'(act[1]), 32'h0);
    rd(STW0 + 32'h4);
    chk(rdv, 32'h0);
    tally_and_finish();
  end
endmodule
